// >>> design/limbo_top.v
// LPDDR init tracker, mode registers and burst column order behind an APB slave
// Summary of operation
// - after full initialization any valid command is accepted
// - mode register set with both bank bits low writes base register
// - base register holds until rewritten, deep power down or power loss
// - bits 2:0 burst length, bit 3 burst type, bits 6:4 read latency
// - burst lengths two, four, eight and sixteen, sequential and interleaved
// - aligned block of burst length chosen by upper column bits, wrapping
// - low column bits give the starting position in the block
// - one programmed burst length serves reads and writes
// - sequential order adds the beat index modulo the burst length
// - interleaved order xors the beat index into the start offset
// - mode register set with bank bits one-zero writes extended register
`include "limbo_regs.vh"
`default_nettype none
module limbo_top #(
  parameter COL_W = 10,
  parameter ADDR_W = 14,
  parameter STAB_CYCLES = `LIMBO_STAB_CYC
) (
  input wire SYS_CLK, // 10 MHz system clock
  input wire RESET_N, // async reset, active low
  input wire CKE, // clock enable from controller
  input wire CS_N, // chip select, active low
  input wire RAS_N, // row strobe, active low
  input wire CAS_N, // column strobe, active low
  input wire WE_N, // write enable, active low
  input wire [1:0] BA, // bank address
  input wire [ADDR_W-1:0] ADDR, // address / mode opcode
  input wire PSEL, // apb select
  input wire PENABLE, // apb enable
  input wire PWRITE, // apb direction
  input wire [`LIMBO_PADDR_W-1:0] PADDR, // apb byte address
  input wire [31:0] PWDATA, // apb write data
  output reg [31:0] PRDATA, // apb read data
  output reg PREADY, // apb ready
  output reg PSLVERR, // apb error on unmapped address
  output reg INIT_DONE, // initialization complete
  output reg [2:0] READ_LATENCY, // programmed read latency
  output wire [COL_W-1:0] BURST_COL, // column of current access
  output wire BURST_VALID, // access in progress
  output wire BURST_WRITE, // access belongs to a write
  output wire BURST_LAST // final access of burst
);
  // ----------------------------------------
  // init states
  // ----------------------------------------
  localparam S_STAB = 2'b00;
  localparam S_PRE = 2'b01;
  localparam S_CFG = 2'b10;
  localparam S_DONE = 2'b11;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`LIMBO_STAB_W-1:0] stab_cnt_reg;
  reg stab_ok_reg;
  reg [1:0] ref_cnt_reg;
  reg pre_seen_reg;
  reg mr_ok_reg;
  reg emr_ok_reg;
  reg seq_err_reg;
  reg rsvd_err_reg;
  reg [ADDR_W-1:0] mode_reg;
  reg [ADDR_W-1:0] ext_reg;
  reg [1:0] ctrl_reg;

  wire sel = ~CS_N & CKE;
  wire [2:0] cmd = {RAS_N, CAS_N, WE_N};
  wire is_nop = CS_N | (cmd == `LIMBO_CMD_NOP);
  wire is_pre_all = sel & (cmd == `LIMBO_CMD_PRE) & ADDR[`LIMBO_AP_BIT];
  wire is_ref = sel & (cmd == `LIMBO_CMD_REF);
  wire is_mrs = sel & (cmd == `LIMBO_CMD_MRS);
  wire mrs_base = is_mrs & (BA == `LIMBO_BA_BASE);
  wire mrs_ext = is_mrs & (BA == `LIMBO_BA_EXT);
  wire is_rd = sel & (cmd == `LIMBO_CMD_READ);
  wire is_wr = sel & (cmd == `LIMBO_CMD_WRITE);
  // deep power down: burst terminate encoding with clock enable low
  wire is_dpd = ~CKE & ~CS_N & (cmd == `LIMBO_CMD_BST);

  // ----------------------------------------
  // mode register decode
  // ----------------------------------------
  wire [2:0] bl_code = mode_reg[`LIMBO_MR_BL_MSB:`LIMBO_MR_BL_LSB];
  wire bt_il = mode_reg[`LIMBO_MR_BT_BIT];
  wire [2:0] rl_code = mode_reg[`LIMBO_MR_RL_MSB:`LIMBO_MR_RL_LSB];
  wire bl_legal = (bl_code >= `LIMBO_BL_2) && (bl_code <= `LIMBO_BL_16);
  wire [2:0] new_bl = ADDR[`LIMBO_MR_BL_MSB:`LIMBO_MR_BL_LSB];
  wire [2:0] new_rl = ADDR[`LIMBO_MR_RL_MSB:`LIMBO_MR_RL_LSB];
  wire new_rsvd = (new_bl < `LIMBO_BL_2) || (new_bl > `LIMBO_BL_16) ||
                  (new_rl < `LIMBO_RL_MIN) || (new_rl > `LIMBO_RL_MAX) ||
                  (|ADDR[ADDR_W-1:`LIMBO_MR_DEF_MSB+1]);

  // reads and writes before init is done are dropped; the strict bit also
  // blocks them while the reserved error flag is set; a reserved length blocks them anyway
  wire burst_go = (is_rd | is_wr) & (state_reg == S_DONE) & ctrl_reg[`LIMBO_CT_BURST_EN] & bl_legal;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
  wire addr_hit = (PADDR == `LIMBO_OFS_STATUS) || (PADDR == `LIMBO_OFS_MODE) ||
                  (PADDR == `LIMBO_OFS_EXT) || (PADDR == `LIMBO_OFS_CTRL);
  wire wr_status = apb_wr & (PADDR == `LIMBO_OFS_STATUS);
  wire wr_ctrl = apb_wr & (PADDR == `LIMBO_OFS_CTRL);
  reg [31:0] status_word;
  reg [31:0] rd_word;

  // ----------------------------------------
  // sequence errors
  // ----------------------------------------
  wire early_cmd = ~is_nop & ~stab_ok_reg & (state_reg == S_STAB);
  wire mrs_busy = (mrs_base | mrs_ext) & BURST_VALID;
  wire bad_step = ~is_nop & ~is_pre_all & (state_reg == S_PRE) & CKE;
  wire err_evt = early_cmd | mrs_busy | bad_step;
  wire rsvd_evt = mrs_base & new_rsvd;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_STAB: begin
        if (stab_ok_reg && is_pre_all) begin
          state_next = S_CFG;
        end else if (stab_ok_reg) begin
          state_next = S_PRE;
        end
      end
      S_PRE: begin
        if (is_pre_all) begin
          state_next = S_CFG;
        end
      end
      S_CFG: begin
        // refreshes may come before or after the two register writes
        if ((ref_cnt_reg == `LIMBO_REF_NEED) && mr_ok_reg && emr_ok_reg) begin
          state_next = S_DONE;
        end
      end
      default: begin
        state_next = S_DONE;
      end
    endcase
    if (is_dpd) begin
      state_next = S_STAB;
    end
  end

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= S_STAB;
      stab_cnt_reg <= {`LIMBO_STAB_W{1'b0}};
      stab_ok_reg <= 1'b0;
      ref_cnt_reg <= 2'h0;
      pre_seen_reg <= 1'b0;
      mr_ok_reg <= 1'b0;
      emr_ok_reg <= 1'b0;
      mode_reg <= {ADDR_W{1'b0}};
      ext_reg <= {ADDR_W{1'b0}};
      INIT_DONE <= 1'b0;
      READ_LATENCY <= 3'h0;
    end else begin
      state_reg <= state_next;
      INIT_DONE <= (state_next == S_DONE);
      // wait counts only cycles with clock enable high
      if (state_reg == S_STAB && !stab_ok_reg && CKE) begin
        if (stab_cnt_reg == STAB_CYCLES[`LIMBO_STAB_W-1:0] - 1'b1) begin
          stab_ok_reg <= 1'b1;
        end
        stab_cnt_reg <= stab_cnt_reg + 1'b1;
      end
      if (is_pre_all && state_reg != S_DONE) begin
        pre_seen_reg <= 1'b1;
      end
      if (is_ref && state_reg == S_CFG && ref_cnt_reg != `LIMBO_REF_NEED) begin
        ref_cnt_reg <= ref_cnt_reg + 2'h1;
      end
      if (mrs_base) begin
        mode_reg <= ADDR;
        READ_LATENCY <= new_rl;
        if (state_reg == S_CFG) begin
          mr_ok_reg <= 1'b1;
        end
      end
      if (mrs_ext) begin
        ext_reg <= ADDR;
        if (state_reg == S_CFG) begin
          emr_ok_reg <= 1'b1;
        end
      end
      if (is_dpd) begin
        // deep power down loses both mode words and the init progress
        mode_reg <= {ADDR_W{1'b0}};
        ext_reg <= {ADDR_W{1'b0}};
        READ_LATENCY <= 3'h0;
        stab_cnt_reg <= {`LIMBO_STAB_W{1'b0}};
        stab_ok_reg <= 1'b0;
        ref_cnt_reg <= 2'h0;
        pre_seen_reg <= 1'b0;
        mr_ok_reg <= 1'b0;
        emr_ok_reg <= 1'b0;
        INIT_DONE <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sticky error flags, write one to clear, a new event wins
  // ----------------------------------------
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_err_reg <= 1'b0;
      rsvd_err_reg <= 1'b0;
    end else begin
      if (err_evt) begin
        seq_err_reg <= 1'b1;
      end else if (wr_status && PWDATA[`LIMBO_ST_SEQERR]) begin
        seq_err_reg <= 1'b0;
      end
      if (rsvd_evt) begin
        rsvd_err_reg <= 1'b1;
      end else if (wr_status && PWDATA[`LIMBO_ST_RSVD]) begin
        rsvd_err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states: ready is registered from the setup cycle and high in the access cycle
  // ----------------------------------------
  always @* begin
    status_word = `LIMBO_RST_WORD;
    status_word[`LIMBO_ST_DONE] = INIT_DONE;
    status_word[`LIMBO_ST_STAB] = stab_ok_reg;
    status_word[`LIMBO_ST_PRE] = pre_seen_reg;
    status_word[`LIMBO_ST_MR] = mr_ok_reg;
    status_word[`LIMBO_ST_EMR] = emr_ok_reg;
    status_word[`LIMBO_ST_SEQERR] = seq_err_reg;
    status_word[`LIMBO_ST_RSVD] = rsvd_err_reg;
    status_word[`LIMBO_ST_REF_MSB:`LIMBO_ST_REF_LSB] = ref_cnt_reg;
    rd_word = `LIMBO_RST_WORD;
    if (PADDR == `LIMBO_OFS_STATUS) begin
      rd_word = status_word;
    end else if (PADDR == `LIMBO_OFS_MODE) begin
      rd_word[ADDR_W-1:0] = mode_reg;
    end else if (PADDR == `LIMBO_OFS_EXT) begin
      rd_word[ADDR_W-1:0] = ext_reg;
    end else if (PADDR == `LIMBO_OFS_CTRL) begin
      rd_word[1:0] = ctrl_reg;
    end
  end

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= `LIMBO_RST_WORD;
      ctrl_reg <= `LIMBO_CTRL_RST;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~addr_hit;
      if (apb_setup && !PWRITE) begin
        PRDATA <= rd_word;
      end
      if (wr_ctrl) begin
        ctrl_reg <= PWDATA[1:0];
      end
    end
  end

  // ----------------------------------------
  // burst column sequencer
  // ----------------------------------------
  wire strict_block = ctrl_reg[`LIMBO_CT_STRICT] & rsvd_err_reg;

  limbo_burst_seq #(
    .COL_W(COL_W)
  ) u_burst (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .start(burst_go & ~strict_block),
    .start_write(is_wr),
    .start_col(ADDR[COL_W-1:0]),
    .len_log2(bl_code),
    .interleave(bt_il),
    .col_out(BURST_COL),
    .valid_out(BURST_VALID),
    .write_out(BURST_WRITE),
    .last_out(BURST_LAST)
  );

  wire unused_ok = &{1'b0, rl_code};
endmodule
`default_nettype wire

// >>> design/limbo_regs.vh
// constants for the LPDDR init, mode register and burst order block
`ifndef LIMBO_REGS_VH
`define LIMBO_REGS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define LIMBO_CLK_PERIOD_NS 100
`define LIMBO_STAB_TIME_NS 200000
`define LIMBO_STAB_CYC ((`LIMBO_STAB_TIME_NS + `LIMBO_CLK_PERIOD_NS - 1) / `LIMBO_CLK_PERIOD_NS)
`define LIMBO_STAB_W 16
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define LIMBO_PADDR_W 8
`define LIMBO_OFS_STATUS 8'h00
`define LIMBO_OFS_MODE 8'h04
`define LIMBO_OFS_EXT 8'h08
`define LIMBO_OFS_CTRL 8'h0c
`define LIMBO_RST_WORD 32'h0000_0000
`define LIMBO_CTRL_RST 2'h1
// status bits
`define LIMBO_ST_DONE 0
`define LIMBO_ST_STAB 1
`define LIMBO_ST_PRE 2
`define LIMBO_ST_MR 3
`define LIMBO_ST_EMR 4
`define LIMBO_ST_SEQERR 5
`define LIMBO_ST_RSVD 6
`define LIMBO_ST_REF_LSB 8
`define LIMBO_ST_REF_MSB 9
// control bits
`define LIMBO_CT_BURST_EN 0
`define LIMBO_CT_STRICT 1
// ----------------------------------------
// command bus: {ras_n, cas_n, we_n} with cs_n low
// ----------------------------------------
`define LIMBO_CMD_NOP 3'h7
`define LIMBO_CMD_ACT 3'h3
`define LIMBO_CMD_READ 3'h5
`define LIMBO_CMD_WRITE 3'h4
`define LIMBO_CMD_BST 3'h6
`define LIMBO_CMD_PRE 3'h2
`define LIMBO_CMD_REF 3'h1
`define LIMBO_CMD_MRS 3'h0
`define LIMBO_AP_BIT 10
`define LIMBO_BA_BASE 2'h0
`define LIMBO_BA_EXT 2'h2
`define LIMBO_REF_NEED 2'h2
// ----------------------------------------
// base mode register fields
// ----------------------------------------
`define LIMBO_MR_BL_LSB 0
`define LIMBO_MR_BL_MSB 2
`define LIMBO_MR_BT_BIT 3
`define LIMBO_MR_RL_LSB 4
`define LIMBO_MR_RL_MSB 6
`define LIMBO_BL_2 3'h1
`define LIMBO_BL_16 3'h4
`define LIMBO_RL_MIN 3'h2
`define LIMBO_RL_MAX 3'h3
`define LIMBO_MR_DEF_MSB 6
`endif

// >>> design/limbo_burst_seq.v
// column sequencer that walks one burst inside its wrapping block
`default_nettype none
module limbo_burst_seq #(
  parameter COL_W = 10
) (
  input wire clk, // system clock
  input wire rst_n, // async reset, active low
  input wire start, // read or write registered this cycle
  input wire start_write, // burst is a write
  input wire [COL_W-1:0] start_col, // column given with the command
  input wire [2:0] len_log2, // log2 of burst length, 1..4
  input wire interleave, // 1 interleaved, 0 sequential
  output reg [COL_W-1:0] col_out, // column of the current access
  output reg valid_out, // one access per cycle while high
  output reg write_out, // current burst is a write
  output reg last_out // final access of the burst
);
  reg [COL_W-1:0] base_reg;
  reg [3:0] off0_reg;
  reg [3:0] k_reg;
  reg [3:0] mask_reg;
  reg il_reg;
  wire [4:0] mask_full;
  wire [3:0] mask_new;
  wire [3:0] off_next;
  wire [COL_W-1:0] mask_col;

  assign mask_full = (5'h01 << len_log2) - 5'h01;
  assign mask_new = mask_full[3:0];
  assign mask_col = {{(COL_W-4){1'b0}}, mask_new};
  // interleave xors the beat index in, sequential adds it; both wrap in the block
  assign off_next = il_reg ? ((off0_reg ^ k_reg) & mask_reg) : ((off0_reg + k_reg) & mask_reg);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= {COL_W{1'b0}};
      off0_reg <= 4'h0;
      k_reg <= 4'h0;
      mask_reg <= 4'h0;
      il_reg <= 1'b0;
      col_out <= {COL_W{1'b0}};
      valid_out <= 1'b0;
      write_out <= 1'b0;
      last_out <= 1'b0;
    end else if (start) begin
      // a new command cuts short any burst still running
      base_reg <= start_col & ~mask_col;
      off0_reg <= start_col[3:0] & mask_new;
      mask_reg <= mask_new;
      il_reg <= interleave;
      k_reg <= 4'h1;
      col_out <= start_col;
      valid_out <= 1'b1;
      write_out <= start_write;
      last_out <= 1'b0;
    end else if (valid_out && !last_out) begin
      col_out <= base_reg | {{(COL_W-4){1'b0}}, off_next};
      last_out <= (k_reg == mask_reg);
      k_reg <= k_reg + 4'h1;
    end else begin
      valid_out <= 1'b0;
      last_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/limbo_top_props.sv
// port assertions for the LPDDR init, mode and burst order block
`include "limbo_regs.vh"
`default_nettype none
module limbo_props #(
  parameter COL_W = 10,
  parameter ADDR_W = 14
) (
  input wire logic SYS_CLK, // clock
  input wire logic RESET_N, // reset
  input wire logic CKE, // clock enable
  input wire logic CS_N, // select
  input wire logic RAS_N, // row strobe
  input wire logic CAS_N, // column strobe
  input wire logic WE_N, // write enable
  input wire logic [1:0] BA, // bank
  input wire logic [ADDR_W-1:0] ADDR, // address
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PREADY, // apb ready
  input wire logic INIT_DONE, // init complete
  input wire logic [2:0] READ_LATENCY, // latency
  input wire logic [COL_W-1:0] BURST_COL, // beat column
  input wire logic BURST_VALID, // beat valid
  input wire logic BURST_WRITE, // beat of a write
  input wire logic BURST_LAST // last beat
);
  // ----
  // mirror of the base mode word and beat index
  // ----
  wire cmd_on = !CS_N && CKE;
  wire mrs_base = cmd_on && !RAS_N && !CAS_N && !WE_N && BA == `LIMBO_BA_BASE;
  wire rw_cmd = cmd_on && RAS_N && !CAS_N;
  wire dpd = !CS_N && !CKE && RAS_N && CAS_N && !WE_N;
  logic [6:0] mode_reg;
  logic [4:0] beat_reg;
  logic [COL_W-1:0] first_reg;
  wire [COL_W-1:0] mask = COL_W'((32'h1 << mode_reg[2:0]) - 32'h1);
  wire [COL_W-1:0] seq_col = (first_reg & ~mask) | ((first_reg + COL_W'(beat_reg)) & mask);
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_reg <= 7'h0;
      beat_reg <= 5'h0;
      first_reg <= {COL_W{1'b0}};
    end else begin
      if (dpd)
        mode_reg <= 7'h0;
      else if (mrs_base)
        mode_reg <= ADDR[6:0];
      if (rw_cmd) begin
        beat_reg <= 5'h0;
        first_reg <= ADDR[COL_W-1:0];
      end else if (BURST_VALID)
        beat_reg <= beat_reg + 5'h1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("pready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("pready too long");
  lat_load_a: assert property (mrs_base |=> READ_LATENCY == $past(ADDR[6:4])) else $error("latency not loaded");
  lat_hold_a: assert property (!mrs_base && !dpd |=> $stable(READ_LATENCY)) else $error("latency moved");
  done_hold_a: assert property (INIT_DONE && !dpd |=> INIT_DONE) else $error("init done dropped");
  no_early_a: assert property (!INIT_DONE |=> !$rose(BURST_VALID)) else $error("burst before init");
  first_col_a: assert property (BURST_VALID && beat_reg == 5'h0 |-> BURST_COL == first_reg) else $error("bad start");
  seq_order_a: assert property (BURST_VALID && !mode_reg[3] |-> BURST_COL == seq_col) else $error("seq order");
  ilv_order_a: assert property (BURST_VALID && mode_reg[3] |-> (BURST_COL ^ first_reg) == COL_W'(beat_reg))
    else $error("interleave order");
  last_beat_a: assert property (BURST_VALID |-> BURST_LAST == (COL_W'(beat_reg) == mask)) else $error("bad length");
  burst_end_a: assert property (BURST_LAST && !rw_cmd |=> !BURST_VALID) else $error("burst overran");
  write_flag_a: assert property ($rose(BURST_VALID) |-> BURST_WRITE == !$past(WE_N)) else $error("bad kind");
  cover property (BURST_LAST && mode_reg[3]);
  cover property (BURST_LAST && !mode_reg[3] && BURST_WRITE);
  cover property (mrs_base ##1 INIT_DONE);
endmodule
bind limbo_top limbo_props #(.COL_W(COL_W), .ADDR_W(ADDR_W)) u_props (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .INIT_DONE(INIT_DONE), .READ_LATENCY(READ_LATENCY),
  .BURST_COL(BURST_COL), .BURST_VALID(BURST_VALID), .BURST_WRITE(BURST_WRITE), .BURST_LAST(BURST_LAST));
`default_nettype wire

// >>> verification/limbo_ctl_model.sv
// command bus model of the memory controller facing the block
`include "limbo_regs.vh"
`default_nettype none
module limbo_ctl_model #(
  parameter int STAB = 8,
  parameter int TRP = 2,
  parameter int TRFC = 3,
  parameter int TMRD = 2
) (
  input wire logic clk, // system clock
  output logic cke, // clock enable
  output logic cs_n, // select, active low
  output logic ras_n, // row strobe
  output logic cas_n, // column strobe
  output logic we_n, // write enable
  output logic [1:0] ba, // bank address
  output logic [13:0] addr // address or opcode
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    ras_n = 1'b1;
    cas_n = 1'b1;
    we_n = 1'b1;
    ba = 2'h0;
    addr = 14'h0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] b, input logic [13:0] a, input logic en);
    @(posedge clk);
    cke <= en;
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= op;
    ba <= b;
    addr <= a;
    @(posedge clk);
    // deselected bus shows the inverse bank and address so stale values never match by luck
    cke <= 1'b1;
    cs_n <= 1'b1;
    ba <= ~b;
    addr <= ~a;
  endtask
  task automatic init_seq(input logic [13:0] base, input logic [13:0] ext);
    idle(STAB + 1);
    cmd(`LIMBO_CMD_PRE, 2'h0, 14'h0400, 1'b1);
    idle(TRP);
    repeat (2) begin
      cmd(`LIMBO_CMD_REF, 2'h0, 14'h0, 1'b1);
      idle(TRFC);
    end
    cmd(`LIMBO_CMD_MRS, `LIMBO_BA_BASE, base, 1'b1);
    idle(TMRD);
    cmd(`LIMBO_CMD_MRS, `LIMBO_BA_EXT, ext, 1'b1);
    idle(TMRD);
  endtask
endmodule
`default_nettype wire

// >>> verification/limbo_top_tb.sv
// self-checking bench for the LPDDR init, mode and burst order block
`include "limbo_regs.vh"
`default_nettype none
module limbo_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STAB = 8;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdata;
  logic rerr;
  wire cke, cs_n, ras_n, cas_n, we_n, pready, pslverr, init_done, burst_valid, burst_write, burst_last;
  wire [1:0] ba;
  wire [13:0] addr;
  wire [31:0] prdata;
  wire [2:0] read_latency;
  wire [9:0] burst_col;
  int num_errors = 0;
  int tests_run = 0;
  always #50 sys_clk = ~sys_clk;
  limbo_ctl_model #(.STAB(STAB)) u_ctl (.clk(sys_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  limbo_top #(.STAB_CYCLES(STAB)) u_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CKE(cke), .CS_N(cs_n),
    .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INIT_DONE(init_done), .READ_LATENCY(read_latency), .BURST_COL(burst_col), .BURST_VALID(burst_valid),
    .BURST_WRITE(burst_write), .BURST_LAST(burst_last));
  // ----
  // shared tasks
  // ----
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask
  task automatic mode_set(input logic [13:0] v, input logic [1:0] b);
    u_ctl.cmd(`LIMBO_CMD_MRS, b, v, 1'b1);
    u_ctl.idle(2);
  endtask
  // beat k of a burst: block kept, offset stepped or xored, wraps inside block
  task automatic burst(input logic wr, input logic [9:0] col, input int bl, input logic il);
    logic [9:0] m;
    logic [9:0] e;
    m = 10'(bl - 1);
    u_ctl.cmd(wr ? `LIMBO_CMD_WRITE : `LIMBO_CMD_READ, 2'h0, {4'h0, col}, 1'b1);
    for (int k = 0; k < bl; k++) begin
      e = il ? (col ^ 10'(k)) : ((col & ~m) | ((col + 10'(k)) & m));
      @(negedge sys_clk);
      check(32'({burst_valid, burst_last, burst_write, burst_col}), 32'({1'b1, k == bl - 1, wr, e}));
    end
    @(negedge sys_clk);
    check(32'(burst_valid), 32'h0);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_early();
    u_ctl.cmd(`LIMBO_CMD_READ, 2'h0, 14'h0, 1'b1);
    @(negedge sys_clk);
    check(32'({init_done, burst_valid}), 32'h0);
    rd(`LIMBO_OFS_STATUS, 32'h20);
    rd(`LIMBO_OFS_CTRL, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check({rerr, rdata[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_init();
    u_ctl.init_seq(14'h0032, 14'h0020);
    check(32'(init_done), 32'h1);
    rd(`LIMBO_OFS_STATUS, 32'h21f);
    rd(`LIMBO_OFS_MODE, 32'h32);
    rd(`LIMBO_OFS_EXT, 32'h20);
    check(32'(read_latency), 32'h3);
  endtask
  task automatic t_bursts();
    for (int c = 1; c <= 4; c++) begin
      for (int il = 0; il < 2; il++) begin
        mode_set(14'(32'h20 | (il << 3) | c), `LIMBO_BA_BASE);
        rd(`LIMBO_OFS_MODE, 32'(32'h20 | (il << 3) | c));
        check(32'(read_latency), 32'h2);
        burst(1'b0, 10'h3ff, 1 << c, il[0]);
        burst(1'b1, 10'h2c5, 1 << c, il[0]);
      end
    end
  endtask
  task automatic t_emrs();
    mode_set(14'h0031, `LIMBO_BA_BASE);
    mode_set(14'h00a5, `LIMBO_BA_EXT);
    rd(`LIMBO_OFS_MODE, 32'h31);
    rd(`LIMBO_OFS_EXT, 32'ha5);
    check(32'(read_latency), 32'h3);
  endtask
  task automatic t_ctrl();
    apb(1'b1, `LIMBO_OFS_CTRL, 32'h0);
    rd(`LIMBO_OFS_CTRL, 32'h0);
    // bursts disabled: a read must not start a burst
    u_ctl.cmd(`LIMBO_CMD_READ, 2'h0, 14'h0005, 1'b1);
    @(negedge sys_clk);
    check(32'(burst_valid), 32'h0);
    apb(1'b1, `LIMBO_OFS_CTRL, 32'h1);
    rd(`LIMBO_OFS_CTRL, 32'h1);
  endtask
  task automatic t_dpd();
    u_ctl.cmd(`LIMBO_CMD_BST, 2'h0, 14'h0, 1'b0);
    @(negedge sys_clk);
    check(32'(init_done), 32'h0);
    rd(`LIMBO_OFS_MODE, 32'h0);
  endtask
  initial begin
    do_reset();
    t_early();
    do_reset();
    t_init();
    t_bursts();
    t_emrs();
    t_ctrl();
    t_dpd();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
